// ==== core/hbs_host_port.sv ====
// Host port top: synchronised slave register access with acknowledge,
// plus the DMA master for bus acquisition and cycle generation.
// Assumes pins are asynchronous to clk_sys; tri-states are resolved outside.
//
// Functional notes
// - Acknowledge only after synchronised select and strobe
// - Acknowledge waits for running DMA to finish
// - Select may come before or after strobe
// - Non-latched register select captured at acknowledge
// - Missed grant slips DMA start four clocks
// - Remote one transfer, local a burst
// - 32-bit mode primes only burst's first transfer
// - Byte bursts hold upper address until end
`timescale 1ns/100ps
module hbs_host_port (
  input wire logic clk_sys, // Bus clock.
  input wire logic resetn, // Asynchronous reset, active low.
  input wire logic cs_n, // Chip select pin.
  input wire logic slave_read_strobe_n, // Slave read strobe pin.
  input wire logic slave_write_strobe_n, // Slave write strobe pin.
  input wire logic address_strobe_zero, // Register select latch strobe.
  input wire logic [hbs_pkg::RS_W-1:0] register_select_lines, // Select.
  output logic ack_n, // Slave access acknowledge.
  output logic [hbs_pkg::RS_W-1:0] reg_select, // Decoded register index.
  output logic reg_read, // One-cycle read pulse to the register file.
  output logic reg_write, // One-cycle write pulse to the register file.
  input wire logic dma_start, // Request a DMA acquisition.
  input wire logic dma_local, // Local burst when high, remote when low.
  input wire logic [hbs_pkg::LEN_W-1:0] dma_len, // Local burst length.
  input wire logic dma_mode32, // 32-bit address mode.
  input wire logic dma_byte_mode, // Byte-wide transfers.
  input wire logic dma_write, // Memory write when high.
  input wire logic [hbs_pkg::ADDR_W-1:0] dma_base_addr, // First address.
  output logic dma_busy, // DMA sequence running.
  output logic dma_done, // One-cycle pulse at sequence end.
  input wire logic bus_grant, // Bus grant pin from the arbiter.
  output logic bus_request_out, // Bus request pin.
  output logic addr_strobe_out, // Address strobe during T1 and primed states.
  output logic [7:0] addr_low, // Low address byte.
  output logic addr_low_oe, // Low address byte drive enable.
  output logic [7:0] upper_address_byte, // Upper address byte.
  output logic upper_address_oe, // Upper address byte drive enable.
  output logic mem_read_n, // Memory read strobe.
  output logic mem_write_n, // Memory write strobe.
  output logic strobe_oe // Strobe and address strobe drive enable.
);
  import hbs_pkg::*;

  localparam int PIN_W = RS_W + 5;

  hbs_dma_if dif ();

  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_s1;
  logic [PIN_W-1:0] pin_s2;

  assign pin_raw = {register_select_lines, address_strobe_zero, cs_n,
                    slave_read_strobe_n, slave_write_strobe_n, bus_grant};

  // Every pin bit passes two flip-flops before any logic reads it.
  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi = gi + 1) begin : g_sync
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          pin_s1[gi] <= 1'b1;
          pin_s2[gi] <= 1'b1;
        end else begin
          pin_s1[gi] <= pin_raw[gi];
          pin_s2[gi] <= pin_s1[gi];
        end
      end
    end
  endgenerate

  logic [RS_W-1:0] rs_s;
  logic latch_open_s, cs_s, rd_s, wr_s, grant_s, access;
  assign rs_s = pin_s2[PIN_W-1 -: RS_W];
  assign latch_open_s = pin_s2[4];
  // Active-high forms of the synchronised low-active pins.
  assign cs_s = !pin_s2[3];
  assign rd_s = !pin_s2[2];
  assign wr_s = !pin_s2[1];
  // Reset value 1 on the grant stage would fake a grant, so invert nothing
  // here but mask grant while no request is out.
  assign grant_s = pin_s2[0] && dif.bus_req;
  // Whichever of select and strobe falls last opens the access.
  assign access = cs_s && (rd_s || wr_s);

  hbs_slave_t sstate, next_sstate;
  logic [RS_W-1:0] rs_latch, next_rs_latch;
  logic [RS_W-1:0] sel, next_sel;
  logic ack, next_ack;
  logic rd_p, next_rd_p;
  logic wr_p, next_wr_p;

  always_comb begin
    next_sstate = sstate;
    next_rs_latch = rs_latch;
    next_sel = sel;
    next_ack = ack;
    next_rd_p = 1'b0;
    next_wr_p = 1'b0;
    // Latch is transparent while the address strobe stays high.
    if (latch_open_s) begin
      next_rs_latch = rs_s;
    end
    case (sstate)
      HBS_S_IDLE: begin
        if (access) begin
          next_sstate = dif.busy ? HBS_S_DMA : HBS_S_ACK;
          if (!dif.busy) begin
            next_ack = 1'b1;
            // Register select is decoded only as acknowledge goes out.
            next_sel = latch_open_s ? rs_s : rs_latch;
            next_rd_p = rd_s;
            next_wr_p = wr_s && !rd_s;
          end
        end
      end
      HBS_S_DMA: begin
        if (!access) begin
          next_sstate = HBS_S_IDLE;
        end else if (!dif.busy) begin
          next_sstate = HBS_S_ACK;
          next_ack = 1'b1;
          next_sel = latch_open_s ? rs_s : rs_latch;
          next_rd_p = rd_s;
          next_wr_p = wr_s && !rd_s;
        end
      end
      HBS_S_ACK: begin
        if (!access) begin
          next_ack = 1'b0;
          next_sstate = HBS_S_END;
        end
      end
      HBS_S_END: next_sstate = HBS_S_IDLE;
      default: begin
        next_sstate = HBS_S_IDLE;
        next_ack = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sstate <= HBS_S_IDLE;
      rs_latch <= '0;
      sel <= '0;
      ack <= 1'b0;
      rd_p <= 1'b0;
      wr_p <= 1'b0;
    end else begin
      sstate <= next_sstate;
      rs_latch <= next_rs_latch;
      sel <= next_sel;
      ack <= next_ack;
      rd_p <= next_rd_p;
      wr_p <= next_wr_p;
    end
  end

  // A new DMA is only started while no slave access is being answered.
  assign dif.start = dma_start && (sstate == HBS_S_IDLE) && !access;
  assign dif.is_local = dma_local;
  assign dif.burst_len = dma_len;
  assign dif.mode32 = dma_mode32;
  assign dif.byte_mode = dma_byte_mode;
  assign dif.write = dma_write;
  assign dif.base_addr = dma_base_addr;
  assign dif.grant = grant_s;

  hbs_dma_master u_dma (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .bus(dif.dma)
  );

  assign ack_n = !ack;
  assign reg_select = sel;
  assign reg_read = rd_p;
  assign reg_write = wr_p;
  assign dma_busy = dif.busy;
  assign dma_done = dif.done;
  assign bus_request_out = dif.bus_req;
  assign addr_strobe_out = dif.ads;
  assign addr_low = dif.addr[7:0];
  assign addr_low_oe = dif.addr_oe;
  assign upper_address_byte = dif.addr[15:8];
  assign upper_address_oe = dif.upper_oe;
  assign mem_read_n = dif.rd_n;
  assign mem_write_n = dif.wr_n;
  assign strobe_oe = dif.strobe_oe;

  AST_ACK_NEEDS_ACCESS: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    $fell(ack_n) |-> $past(access))
    else $error("Acknowledge issued without synchronised access.");
  AST_ACK_AFTER_DMA: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    $fell(ack_n) |-> $past(!dif.busy))
    else $error("Acknowledge issued while DMA was running.");
  AST_ACK_FROM_LAST_EDGE: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (sstate == HBS_S_IDLE && access && !dif.busy) |=>
      !ack_n && (reg_read || reg_write))
    else $error("Acknowledge not one clock after access opened.");
  AST_SEL_AT_ACK: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (!ack_n && $past(!ack_n)) |-> $stable(reg_select))
    else $error("Register select changed while acknowledged.");
  AST_NO_ACK_IN_IDLE: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (sstate == HBS_S_IDLE) |-> ack_n)
    else $error("Acknowledge low with no access open.");
  AST_ACK_WAITS_DMA: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (sstate == HBS_S_DMA) |-> ack_n)
    else $error("Acknowledge low while waiting for DMA.");
  AST_ACK_DROPS: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (!ack_n && !access) |=> ack_n)
    else $error("Acknowledge held after the access closed.");
  AST_PULSE_ONE: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (reg_read || reg_write) |=> !(reg_read || reg_write))
    else $error("Register access pulse longer than one clock.");
endmodule

// ==== core/hbs_pkg.sv ====
// Shared constants and types of the host bus slave and DMA master.
// Assumes one bus clock domain; all pins arrive through synchronisers.
package hbs_pkg;
  localparam int SYNC_STAGES = 2;
  localparam int RS_W = 4;
  localparam int ADDR_W = 16;
  localparam int LEN_W = 5;
  // Grant missed before the first cycle state slips the DMA start.
  localparam logic [2:0] SLIP_CLKS = 3'h4;
  // Primed cycle states issued ahead of a burst in 32-bit address mode.
  localparam logic [2:0] PRIME_STATES = 3'h4;
  localparam logic [LEN_W-1:0] ONE_XFER = 5'h01;

  typedef enum logic [3:0] {
    HBS_S_IDLE = 4'b0001,
    HBS_S_DMA = 4'b0010,
    HBS_S_ACK = 4'b0100,
    HBS_S_END = 4'b1000
  } hbs_slave_t;

  typedef enum logic [9:0] {
    HBS_D_IDLE = 10'b00_0000_0001,
    HBS_D_REQ = 10'b00_0000_0010,
    HBS_D_SLIP = 10'b00_0000_0100,
    HBS_D_PRIME = 10'b00_0000_1000,
    HBS_D_T1 = 10'b00_0001_0000,
    HBS_D_T2 = 10'b00_0010_0000,
    HBS_D_T3 = 10'b00_0100_0000,
    HBS_D_T4 = 10'b00_1000_0000,
    HBS_D_REL = 10'b01_0000_0000,
    HBS_D_SPARE = 10'b10_0000_0000
  } hbs_dma_t;
endpackage

// ==== core/hbs_dma_if.sv ====
// Carrier between the host port top and its DMA master.
// Assumes both ends run on clk_sys.
`timescale 1ns/100ps
interface hbs_dma_if;
  import hbs_pkg::*;
  logic start;
  logic is_local;
  logic [LEN_W-1:0] burst_len;
  logic mode32;
  logic byte_mode;
  logic write;
  logic [ADDR_W-1:0] base_addr;
  logic grant;
  logic busy;
  logic done;
  logic bus_req;
  logic ads;
  logic [ADDR_W-1:0] addr;
  logic addr_oe;
  logic upper_oe;
  logic rd_n;
  logic wr_n;
  logic strobe_oe;
  modport ctl (output start, is_local, burst_len, mode32, byte_mode, write,
    base_addr, grant, input busy, done, bus_req, ads, addr, addr_oe,
    upper_oe, rd_n, wr_n, strobe_oe);
  modport dma (input start, is_local, burst_len, mode32, byte_mode, write,
    base_addr, grant, output busy, done, bus_req, ads, addr, addr_oe,
    upper_oe, rd_n, wr_n, strobe_oe);
endinterface

// ==== core/hbs_dma_master.sv ====
// Bus master sequencer: arbitration, primed states, T1 to T4 cycles.
// Assumes grant is already synchronised and start is held until busy.
`timescale 1ns/100ps
module hbs_dma_master (
  input wire logic clk_sys, // Bus clock.
  input wire logic resetn, // Asynchronous reset, active low.
  hbs_dma_if.dma bus // Control from the top and bus-side drives.
);
  import hbs_pkg::*;

  hbs_dma_t state, next_state;
  logic [2:0] cnt, next_cnt;
  logic [LEN_W-1:0] left, next_left;
  logic [ADDR_W-1:0] addr, next_addr;
  logic first, next_first;
  logic hold_upper, next_hold_upper;
  logic req, next_req;
  logic local_xfer, next_local_xfer;
  logic m32, next_m32;
  logic bytew, next_bytew;
  logic wr, next_wr;
  logic done, next_done;
  logic in_cycle;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_left = left;
    next_addr = addr;
    next_first = first;
    next_hold_upper = hold_upper;
    next_req = req;
    next_local_xfer = local_xfer;
    next_m32 = m32;
    next_bytew = bytew;
    next_wr = wr;
    next_done = 1'b0;
    case (state)
      HBS_D_IDLE: begin
        if (bus.start) begin
          next_state = HBS_D_REQ;
          next_req = 1'b1;
          next_local_xfer = bus.is_local;
          // Remote DMA moves one transfer per acquisition.
          next_left = (bus.is_local && bus.burst_len != '0) ?
                      bus.burst_len : ONE_XFER;
          next_addr = bus.base_addr;
          next_m32 = bus.mode32;
          next_bytew = bus.byte_mode;
          next_wr = bus.write;
          next_first = 1'b1;
        end
      end
      HBS_D_REQ: begin
        next_cnt = 3'h0;
        if (!bus.grant) begin
          next_state = HBS_D_SLIP;
        end else if (m32) begin
          next_state = HBS_D_PRIME;
        end else begin
          next_state = HBS_D_T1;
        end
      end
      HBS_D_SLIP: begin
        next_cnt = cnt + 3'h1;
        if (cnt == SLIP_CLKS - 3'h1) begin
          next_state = HBS_D_REQ;
        end
      end
      HBS_D_PRIME: begin
        next_cnt = cnt + 3'h1;
        if (cnt == PRIME_STATES - 3'h1) begin
          next_state = HBS_D_T1;
        end
      end
      HBS_D_T1: begin
        next_state = HBS_D_T2;
        next_first = 1'b0;
        next_hold_upper = bytew;
      end
      HBS_D_T2: next_state = HBS_D_T3;
      HBS_D_T3: next_state = HBS_D_T4;
      HBS_D_T4: begin
        next_left = left - ONE_XFER;
        // The upper byte lets go with the rest after the last transfer.
        next_hold_upper = bytew && (left != ONE_XFER);
        next_addr = addr + 16'h0001;
        // Later transfers of a burst go straight to T1.
        next_state = (left == ONE_XFER) ? HBS_D_REL : HBS_D_T1;
      end
      HBS_D_REL: begin
        // Drives are already off; request drops one clock later.
        next_hold_upper = 1'b0;
        next_req = 1'b0;
        next_done = 1'b1;
        next_state = HBS_D_IDLE;
      end
      default: begin
        next_state = HBS_D_IDLE;
        next_req = 1'b0;
        next_hold_upper = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state <= HBS_D_IDLE;
      cnt <= 3'h0;
      left <= '0;
      addr <= '0;
      first <= 1'b0;
      hold_upper <= 1'b0;
      req <= 1'b0;
      local_xfer <= 1'b0;
      m32 <= 1'b0;
      bytew <= 1'b0;
      wr <= 1'b0;
      done <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      left <= next_left;
      addr <= next_addr;
      first <= next_first;
      hold_upper <= next_hold_upper;
      req <= next_req;
      local_xfer <= next_local_xfer;
      m32 <= next_m32;
      bytew <= next_bytew;
      wr <= next_wr;
      done <= next_done;
    end
  end

  assign in_cycle = (state == HBS_D_PRIME) || (state == HBS_D_T1) ||
                    (state == HBS_D_T2) || (state == HBS_D_T3) ||
                    (state == HBS_D_T4);
  assign bus.bus_req = req;
  assign bus.busy = (state != HBS_D_IDLE);
  assign bus.done = done;
  assign bus.addr = addr;
  assign bus.addr_oe = in_cycle;
  // Byte mode keeps the upper byte driven between burst transfers.
  assign bus.upper_oe = in_cycle || hold_upper;
  assign bus.strobe_oe = in_cycle;
  assign bus.ads = (state == HBS_D_T1) || (state == HBS_D_PRIME);
  assign bus.rd_n = !(!wr && (state == HBS_D_T2 || state == HBS_D_T3));
  assign bus.wr_n = !(wr && (state == HBS_D_T2 || state == HBS_D_T3));

  // Transfers counted per acquisition, read by the checks only.
  logic [LEN_W-1:0] xfers;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      xfers <= '0;
    end else if (state == HBS_D_IDLE) begin
      xfers <= '0;
    end else if (state == HBS_D_T4) begin
      xfers <= xfers + ONE_XFER;
    end
  end

  AST_GRANT_SLIP: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (state == HBS_D_REQ && !bus.grant) |=>
      (state == HBS_D_SLIP) [*4] ##1 (state == HBS_D_REQ))
    else $error("Missed grant did not slip by four clocks.");
  AST_REMOTE_SINGLE: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (state == HBS_D_REL && !local_xfer) |-> (xfers == ONE_XFER))
    else $error("Remote DMA did more than one transfer.");
  AST_PRIME_FIRST_ONLY: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (state == HBS_D_T4 && left != ONE_XFER) |=> (state == HBS_D_T1))
    else $error("Primed states repeated inside a burst.");
  AST_PRIME_BEFORE_FIRST: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (state == HBS_D_PRIME) |-> (first && m32))
    else $error("Primed state outside the first transfer of a burst.");
  AST_UPPER_HELD: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (state == HBS_D_T4 && bytew && left != ONE_XFER) |=> bus.upper_oe)
    else $error("Upper address byte released inside a byte burst.");
  AST_UPPER_RELEASED: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (state == HBS_D_T4 && left == ONE_XFER) |=> !bus.upper_oe)
    else $error("Upper address byte still driven after the last transfer.");
  AST_RELEASE_ORDER: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (state == HBS_D_REL) |-> (bus.bus_req && !bus.addr_oe && !bus.upper_oe
      && !bus.strobe_oe) ##1 !bus.bus_req)
    else $error("Bus request dropped before drives released.");
endmodule

// ==== verification/hbs_arb_model.sv ====
// Bus arbiter seen from the host port: parks grant or grants late.
// Assumes it shares clk_sys and resetn with the device.
`timescale 1ns/100ps
module hbs_arb_model (
  input wire logic clk_sys, // Bus clock.
  input wire logic resetn, // Asynchronous reset, active low.
  input wire logic bus_request_out, // Request from the device.
  input wire logic slow, // Late grant when high.
  output logic bus_grant // Grant back to the device.
);
  logic dly;
  logic next_dly;
  logic next_grant;

  // A slow arbiter grants two clocks after the request and so misses
  // the first sample; a prompt one keeps grant parked high.
  always_comb begin
    next_dly = bus_request_out;
    next_grant = bus_request_out ? (dly | ~slow) : ~slow;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      dly <= 1'b0;
      bus_grant <= 1'b0;
    end else begin
      dly <= next_dly;
      bus_grant <= next_grant;
    end
  end
endmodule

// ==== verification/host_bus_slave_and_dma_master_tb.sv ====
// Self-checking bench of the host port: slave accesses and DMA runs.
// Assumes the arbiter model above; memory data is not modelled.
`timescale 1ns/100ps
module host_bus_slave_and_dma_master_tb;
  import hbs_pkg::*;
  logic clk_sys, resetn, cs_n, slave_read_strobe_n, slave_write_strobe_n;
  logic address_strobe_zero, ack_n, reg_read, reg_write, slow;
  logic [RS_W-1:0] register_select_lines, reg_select;
  logic dma_start, dma_local, dma_mode32, dma_byte_mode, dma_write;
  logic [LEN_W-1:0] dma_len;
  logic [ADDR_W-1:0] dma_base_addr;
  logic dma_busy, dma_done, bus_grant, bus_request_out, addr_strobe_out;
  logic [7:0] addr_low, upper_address_byte;
  logic addr_low_oe, upper_address_oe, mem_read_n, mem_write_n, strobe_oe;
  logic [31:0] rs;
  int fail_count, n_compared, cyc, i;

  hbs_host_port hbs_host_port_i (.clk_sys, .resetn, .cs_n,
    .slave_read_strobe_n, .slave_write_strobe_n, .address_strobe_zero,
    .register_select_lines, .ack_n, .reg_select, .reg_read, .reg_write,
    .dma_start, .dma_local, .dma_len, .dma_mode32, .dma_byte_mode,
    .dma_write, .dma_base_addr, .dma_busy, .dma_done, .bus_grant,
    .bus_request_out, .addr_strobe_out, .addr_low, .addr_low_oe,
    .upper_address_byte, .upper_address_oe, .mem_read_n, .mem_write_n,
    .strobe_oe);
  hbs_arb_model hbs_arb_model_i (.clk_sys, .resetn, .bus_request_out,
    .slow, .bus_grant);

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction

  task automatic conclude();
    if (fail_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      conclude();
    end
  end

  // A latency of zero means the access overlaps a DMA and is not timed.
  task automatic slave_acc(input logic wr, late, lat, input logic [3:0] sel,
    input int lat_exp);
    int n;
    @(negedge clk_sys);
    register_select_lines = (late && !lat) ? ~sel : sel;
    address_strobe_zero = 1'b1;
    if (lat) begin
      @(negedge clk_sys);
      address_strobe_zero = 1'b0;
      @(negedge clk_sys);
      register_select_lines = ~sel;
    end
    if (late) begin
      {slave_read_strobe_n, slave_write_strobe_n} = wr ? 2'b10 : 2'b01;
      repeat (4) @(negedge clk_sys);
      check("ack before cs", ack_n, 1'b1);
      if (!lat) register_select_lines = sel;
      @(negedge clk_sys);
      cs_n = 1'b0;
    end else begin
      cs_n = 1'b0;
      @(negedge clk_sys);
      {slave_read_strobe_n, slave_write_strobe_n} = wr ? 2'b10 : 2'b01;
    end
    n = 0;
    while (ack_n !== 1'b0 && n < 400) begin
      @(negedge clk_sys);
      n++;
      if (dma_busy === 1'b1) check("ack in dma", ack_n, 1'b1);
    end
    check("ack seen", ack_n, 1'b0);
    if (lat_exp > 0) check("ack latency", n, lat_exp);
    check("read pulse", reg_read, !wr);
    check("write pulse", reg_write, wr);
    check("select", reg_select, sel);
    @(negedge clk_sys);
    check("pulse end", {reg_read, reg_write}, 2'b00);
    {cs_n, slave_read_strobe_n, slave_write_strobe_n} = 3'b111;
    repeat (4) @(negedge clk_sys);
    check("ack release", ack_n, 1'b1);
    address_strobe_zero = 1'b1;
    @(negedge clk_sys);
  endtask

  task automatic dma_run(input logic loc, m32, byt, wr, slow_g,
    input logic [4:0] len, input logic [15:0] base);
    int nx, nads, gap, xf, k;
    logic [15:0] q[$];
    logic prev_s, prev_r, prev_oe, s;
    nx = (loc && len != 0) ? int'(len) : 1;
    for (k = 0; k < nx; k++) q.push_back(base + 16'(k));
    nads = 0;
    gap = 0;
    xf = 0;
    prev_s = 1'b1;
    prev_r = 1'b0;
    prev_oe = 1'b0;
    @(negedge clk_sys);
    slow = slow_g;
    {dma_local, dma_mode32, dma_byte_mode, dma_write} = {loc, m32, byt, wr};
    dma_len = len;
    dma_base_addr = base;
    // A grant the arbiter has withdrawn needs three clocks to leave the
    // synchroniser; asking sooner would meet the stale grant.
    repeat (3) @(negedge clk_sys);
    dma_start = 1'b1;
    for (k = 0; k < 500 && dma_done !== 1'b1; k++) begin
      @(negedge clk_sys);
      if (dma_busy === 1'b1) dma_start = 1'b0;
      s = wr ? mem_write_n : mem_read_n;
      if (addr_strobe_out === 1'b1) nads++;
      else if (nads == 0 && bus_request_out === 1'b1) gap++;
      if (s === 1'b0 && prev_s === 1'b1) begin
        check("address", {upper_address_byte, addr_low},
          q.pop_front());
        check("idle strobe", wr ? mem_read_n : mem_write_n, 1'b1);
        xf++;
      end
      if (byt && xf > 0 && xf < nx) begin
        check("upper held", upper_address_oe, 1'b1);
      end
      if (prev_r === 1'b1 && bus_request_out === 1'b0) begin
        check("drive off", prev_oe, 1'b0);
      end
      prev_s = s;
      prev_r = bus_request_out;
      prev_oe = strobe_oe | addr_low_oe | upper_address_oe;
    end
    check("done", dma_done, 1'b1);
    check("transfers", xf, nx);
    check("strobe states", nads, nx + (m32 ? 4 : 0));
    // One request clock, plus the slip and a second request clock.
    check("grant gap", gap, slow_g ? 2 + int'(SLIP_CLKS) : 1);
    check("upper off", upper_address_oe, 1'b0);
    check("request off", bus_request_out, 1'b0);
    check("busy off", dma_busy, 1'b0);
  endtask

  initial begin
    {cs_n, slave_read_strobe_n, slave_write_strobe_n} = 3'b111;
    address_strobe_zero = 1'b1;
    register_select_lines = 4'h0;
    {dma_start, dma_local, dma_mode32, dma_byte_mode, dma_write} = 5'h00;
    dma_len = 5'h00;
    dma_base_addr = 16'h0000;
    slow = 1'b0;
    resetn = 1'b0;
    rs = 32'h0000000f;
    repeat (16) @(negedge clk_sys);
    resetn = 1'b1;
    repeat (4) @(negedge clk_sys);
    check("reset", {ack_n, bus_request_out, strobe_oe, addr_low_oe},
      4'h8);
    for (i = 0; i < 8; i++) begin
      rs = xs(rs);
      slave_acc(i[0], i[1], i[2], rs[3:0], 3);
    end
    for (i = 0; i < 8; i++) begin
      rs = xs(rs);
      dma_run(i[0], i[1], i[2], rs[5], rs[6], i == 1 ? 5'h00 : rs[4:0],
        rs[31:16]);
    end
    fork
      dma_run(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 5'h08, 16'h00fe);
      begin
        repeat (4) @(negedge clk_sys);
        slave_acc(1'b0, 1'b0, 1'b0, 4'h5, 0);
      end
    join
    conclude();
  end
endmodule
